/* File: logic/phase_pattern_pkg.sv */
/*
 Package: register addresses, field positions, power-on values and
 test-pattern words for the clock-phase and test-pattern register bank.
 Assumes a 16-bit write word and a 4-bit register address from the serial port.
*/
package phase_pattern_pkg;
   localparam logic [3:0] ADDR_FINE_PHASE = 4'hD;
   localparam logic [3:0] ADDR_COARSE_PHASE = 4'hE;
   localparam logic [3:0] ADDR_PATTERN_CTRL = 4'hF;
   localparam logic [15:0] FINE_PHASE_POR = 16'h007F;
   localparam logic [15:0] COARSE_PHASE_POR = 16'h03FF;
   localparam logic [15:0] PATTERN_CTRL_POR = 16'hF7FF;
   localparam int FINE_MAG_HI = 15;
   localparam int FINE_MAG_LO = 7;
   localparam int PHASE_EN_BIT = 15;
   localparam int COARSE_MAG_HI = 14;
   localparam int COARSE_MAG_LO = 11;
   localparam int SLOW_CLK_BIT = 10;
   localparam int PATTERN_EN_BIT = 11;
   localparam int SER_BITS = 24;
   localparam logic [4:0] SER_BITS_M1 = 5'h17;
   localparam int ADDR_FIELD_HI = 19;
   localparam int ADDR_FIELD_LO = 16;
   localparam int DATA_FIELD_HI = 15;
   localparam int DATA_FIELD_LO = 0;
   localparam int PATTERN_DELAY = 10;
   localparam logic [3:0] PATTERN_DELAY_CNT = 4'hA;
   localparam logic [3:0] PATTERN_LEN = 4'h9;
   localparam logic [9:0] PATTERN_SEQ = 10'h14A;
   localparam logic [7:0] PORT_A_WORD = 8'h01;
   localparam logic [7:0] PORT_B_WORD = 8'h02;
   localparam logic [7:0] PORT_C_WORD = 8'h03;
   localparam logic [7:0] PORT_D_WORD = 8'h04;

   typedef struct packed {
      logic [7:0] port_a;
      logic [7:0] port_b;
      logic [7:0] port_c;
      logic [7:0] port_d;
      logic out_of_range;
   } sample_out_t;

   typedef struct packed {
      logic phase_adjust_enable;
      logic [3:0] coarse_delay_magnitude;
      logic [8:0] fine_delay_magnitude;
      logic slow_sample_clock_select;
   } phase_cfg_t;
endpackage

/* File: logic/pattern_gen.sv */
/*
 Test-pattern generator: steps through the repeating word sequence.
 Assumes it is advanced once per output sample by the owner.
*/
`timescale 1ns/1ns
`default_nettype none
module pattern_gen
   import phase_pattern_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic run,
   output sample_out_t word
);
   logic [3:0] step_reg;
   logic [3:0] step_next;
   logic inv;
   assign step_next = (!run || step_reg == PATTERN_LEN) ? 4'h0 : step_reg + 4'h1;
   assign inv = PATTERN_SEQ[step_reg];
   // Complement alternation with OR flag
   assign word = '{port_a: inv ? ~PORT_A_WORD : PORT_A_WORD,
                   port_b: inv ? ~PORT_B_WORD : PORT_B_WORD,
                   port_c: inv ? ~PORT_C_WORD : PORT_C_WORD,
                   port_d: inv ? ~PORT_D_WORD : PORT_D_WORD,
                   out_of_range: inv};
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         step_reg <= 4'h0;
      end else begin
         step_reg <= step_next;
      end
   end
endmodule
`default_nettype wire

/* File: logic/phase_pattern_regs.sv */
/*
 Write-only clock-phase and test-pattern registers with the output mux.
 Assumes SCLK/SCS_B/SDATA from a host, asynchronous to MCLK; MCLK paces output words.
*/
`timescale 1ns/1ns
`default_nettype none
module phase_pattern_regs
   import phase_pattern_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic SCLK,
   input wire logic SCS_B,
   input wire logic SDATA,
   input wire logic DDR_MODE,
   input wire logic [7:0] CORE_A,
   input wire logic [7:0] CORE_B,
   input wire logic [7:0] CORE_C,
   input wire logic [7:0] CORE_D,
   input wire logic CORE_OR,
   output logic [7:0] PORT_A,
   output logic [7:0] PORT_B,
   output logic [7:0] PORT_C,
   output logic [7:0] PORT_D,
   output logic OUT_OF_RANGE,
   output logic PHASE_ADJUST_ENABLE,
   output logic [8:0] FINE_DELAY_MAGNITUDE,
   output logic [3:0] COARSE_DELAY_MAGNITUDE,
   output logic SLOW_SAMPLE_CLOCK_SELECT,
   output logic PATTERN_OUTPUT_ENABLE
);
   // Pin synchronisers: two stages each, then an edge stage for SCLK and SCS_B only
   logic [2:0] sclk_sync_reg;
   logic [2:0] sclk_sync_next;
   logic [2:0] scs_sync_reg;
   logic [2:0] scs_sync_next;
   logic [1:0] sdata_sync_reg;
   logic [1:0] sdata_sync_next;
   logic sclk_rise;
   logic frame_end;
   logic frame_open;
   logic sample_bit;

   // Serial capture
   logic [SER_BITS-1:0] shift_reg;
   logic [SER_BITS-1:0] shift_next;
   logic [4:0] bit_cnt_reg;
   logic [4:0] bit_cnt_next;
   logic frame_full;
   logic shift_en;

   // Write decode
   logic [3:0] wr_addr;
   logic [15:0] wr_data;
   logic wr_valid;
   logic wr_fine;
   logic wr_coarse;
   logic wr_pattern;

   // Stored words
   logic [15:0] fine_reg;
   logic [15:0] fine_next;
   logic [15:0] coarse_reg;
   logic [15:0] coarse_next;
   logic [15:0] pattern_reg;
   logic [15:0] pattern_next;

   // Pattern switch-over
   logic [3:0] delay_reg;
   logic [3:0] delay_next;
   logic delay_done;
   logic pattern_on_reg;
   logic pattern_on_next;

   // Output selection
   phase_cfg_t cfg;
   sample_out_t gen_word;
   sample_out_t core_word;
   sample_out_t out_word;

   assign sclk_sync_next = {sclk_sync_reg[1:0], SCLK};
   assign scs_sync_next = {scs_sync_reg[1:0], SCS_B};
   assign sdata_sync_next = {sdata_sync_reg[0], SDATA};
   assign sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];
   assign frame_end = scs_sync_reg[1] && !scs_sync_reg[2];
   assign frame_open = !scs_sync_reg[1];
   assign sample_bit = sdata_sync_reg[1];

   // MSB first, 24 bits per frame; extra clocks ignored
   assign frame_full = bit_cnt_reg == SER_BITS_M1 + 5'h1;
   assign shift_en = frame_open && sclk_rise && !frame_full;
   assign shift_next = shift_en ? {shift_reg[SER_BITS-2:0], sample_bit} : shift_reg;
   assign bit_cnt_next = !frame_open ? 5'h0 : (shift_en ? bit_cnt_reg + 5'h1 : bit_cnt_reg);

   // Short frames are dropped
   assign wr_valid = frame_end && frame_full;
   assign wr_addr = shift_reg[ADDR_FIELD_HI:ADDR_FIELD_LO];
   assign wr_data = shift_reg[DATA_FIELD_HI:DATA_FIELD_LO];
   assign wr_fine = wr_valid && wr_addr == ADDR_FINE_PHASE;
   assign wr_coarse = wr_valid && wr_addr == ADDR_COARSE_PHASE;
   assign wr_pattern = wr_valid && wr_addr == ADDR_PATTERN_CTRL;

   // Whole words kept; reserved bits stored as written
   assign fine_next = wr_fine ? wr_data : fine_reg;
   assign coarse_next = wr_coarse ? wr_data : coarse_reg;
   assign pattern_next = wr_pattern ? wr_data : pattern_reg;

   // Enable gates both magnitudes
   assign cfg.phase_adjust_enable = coarse_reg[PHASE_EN_BIT];
   assign cfg.fine_delay_magnitude = cfg.phase_adjust_enable ? fine_reg[FINE_MAG_HI:FINE_MAG_LO] : 9'h000;
   assign cfg.coarse_delay_magnitude =
      cfg.phase_adjust_enable ? coarse_reg[COARSE_MAG_HI:COARSE_MAG_LO] : 4'h0;
   assign cfg.slow_sample_clock_select = coarse_reg[SLOW_CLK_BIT];

   // Delay restarts on every pattern-register write
   assign delay_next = wr_pattern ? PATTERN_DELAY_CNT : (delay_reg != 4'h0 ? delay_reg - 4'h1 : 4'h0);
   assign delay_done = delay_reg == 4'h1;
   assign pattern_on_next = delay_done ? pattern_reg[PATTERN_EN_BIT] : pattern_on_reg;

   // One word per output clock regardless of DDR_MODE
   assign core_word = '{CORE_A, CORE_B, CORE_C, CORE_D, CORE_OR};
   assign out_word = pattern_on_reg ? gen_word : core_word;

   pattern_gen u_gen (
      .clk(MCLK),
      .rst_b(RST_B),
      .run(pattern_on_reg),
      .word(gen_word)
   );

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         sclk_sync_reg <= 3'h0;
         scs_sync_reg <= 3'h7;
         sdata_sync_reg <= 2'h0;
      end else begin
         sclk_sync_reg <= sclk_sync_next;
         scs_sync_reg <= scs_sync_next;
         sdata_sync_reg <= sdata_sync_next;
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         shift_reg <= '0;
         bit_cnt_reg <= 5'h0;
      end else begin
         shift_reg <= shift_next;
         bit_cnt_reg <= bit_cnt_next;
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         fine_reg <= FINE_PHASE_POR;
         coarse_reg <= COARSE_PHASE_POR;
         pattern_reg <= PATTERN_CTRL_POR;
      end else begin
         fine_reg <= fine_next;
         coarse_reg <= coarse_next;
         pattern_reg <= pattern_next;
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         delay_reg <= 4'h0;
         pattern_on_reg <= 1'b0;
      end else begin
         delay_reg <= delay_next;
         pattern_on_reg <= pattern_on_next;
      end
   end

   // Data ports and flag
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         PORT_A <= 8'h00;
         PORT_B <= 8'h00;
         PORT_C <= 8'h00;
         PORT_D <= 8'h00;
         OUT_OF_RANGE <= 1'b0;
         PATTERN_OUTPUT_ENABLE <= 1'b0;
      end else begin
         PORT_A <= out_word.port_a;
         PORT_B <= out_word.port_b;
         PORT_C <= out_word.port_c;
         PORT_D <= out_word.port_d;
         OUT_OF_RANGE <= out_word.out_of_range;
         PATTERN_OUTPUT_ENABLE <= pattern_on_reg;
      end
   end

   // Phase settings
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         PHASE_ADJUST_ENABLE <= 1'b0;
         FINE_DELAY_MAGNITUDE <= 9'h000;
         COARSE_DELAY_MAGNITUDE <= 4'h0;
         SLOW_SAMPLE_CLOCK_SELECT <= 1'b0;
      end else begin
         PHASE_ADJUST_ENABLE <= cfg.phase_adjust_enable;
         FINE_DELAY_MAGNITUDE <= cfg.fine_delay_magnitude;
         COARSE_DELAY_MAGNITUDE <= cfg.coarse_delay_magnitude;
         SLOW_SAMPLE_CLOCK_SELECT <= cfg.slow_sample_clock_select;
      end
   end
endmodule
`default_nettype wire

/* File: tb/serial_host.sv */
/*
 Host model: sends 24-bit write frames MSB first.
 Assumes MCLK from the bench; SCLK is high for 4 MCLK and low for 5 MCLK between bits.
*/
`timescale 1ns/1ns
`default_nettype none
module serial_host (
   input wire logic MCLK,
   output logic SCLK,
   output logic SCS_B,
   output logic SDATA
);
   initial begin
      SCLK = 1'b0;
      SCS_B = 1'b1;
      SDATA = 1'b0;
   end
   task automatic send(input logic [3:0] addr, input logic [15:0] data);
      logic [23:0] f;
      f = {4'hF, addr, data};
      for (int i = 23; i >= 0; i--) begin
         @(negedge MCLK);
         SCS_B = 1'b0;
         SDATA = f[i];
         repeat (4) @(negedge MCLK);
         SCLK = 1'b1;
         repeat (4) @(negedge MCLK);
         SCLK = 1'b0;
      end
      repeat (4) @(negedge MCLK);
      SCS_B = 1'b1;
      SDATA = ~SDATA;
      repeat (4) @(negedge MCLK);
   endtask
endmodule
`default_nettype wire

/* File: tb/phase_pattern_monitor.sv */
/*
 Checker for the phase and pattern register outputs.
 Assumes binding to phase_pattern_regs.
*/
`timescale 1ns/1ns
`default_nettype none
module phase_pattern_monitor (
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic SCS_B,
   input wire logic [7:0] CORE_A,
   input wire logic CORE_OR,
   input wire logic [7:0] PORT_A,
   input wire logic [7:0] PORT_B,
   input wire logic [7:0] PORT_C,
   input wire logic [7:0] PORT_D,
   input wire logic OUT_OF_RANGE,
   input wire logic PHASE_ADJUST_ENABLE,
   input wire logic [8:0] FINE_DELAY_MAGNITUDE,
   input wire logic [3:0] COARSE_DELAY_MAGNITUDE,
   input wire logic SLOW_SAMPLE_CLOCK_SELECT,
   input wire logic PATTERN_OUTPUT_ENABLE
);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_B);
   sequence pat_run_s;
      PATTERN_OUTPUT_ENABLE[*8] ##1 PATTERN_OUTPUT_ENABLE[*3];
   endsequence
   pat_start_a: assert property ($rose(PATTERN_OUTPUT_ENABLE) |-> PORT_A == 8'h01 && !OUT_OF_RANGE)
      else $error("pattern start word wrong");
   pat_words_a: assert property (PATTERN_OUTPUT_ENABLE |->
      {PORT_A, PORT_B, PORT_C, PORT_D} == (OUT_OF_RANGE ? 32'hFEFDFCFB : 32'h01020304))
      else $error("pattern word wrong");
   pat_period_a: assert property (pat_run_s |-> OUT_OF_RANGE == $past(OUT_OF_RANGE, 10))
      else $error("pattern period wrong");
   core_pass_a: assert property ($past(RST_B) && !$past(PATTERN_OUTPUT_ENABLE) && !PATTERN_OUTPUT_ENABLE
      |-> PORT_A == $past(CORE_A) && OUT_OF_RANGE == $past(CORE_OR))
      else $error("core data not passed");
   fine_gate_a: assert property (FINE_DELAY_MAGNITUDE != 9'h000 |-> PHASE_ADJUST_ENABLE)
      else $error("fine delay without enable");
   coarse_gate_a: assert property (COARSE_DELAY_MAGNITUDE != 4'h0 |-> PHASE_ADJUST_ENABLE)
      else $error("coarse delay without enable");
   cfg_hold_a: assert property ((!SCS_B)[*6] |-> $stable({FINE_DELAY_MAGNITUDE, COARSE_DELAY_MAGNITUDE,
      PHASE_ADJUST_ENABLE, SLOW_SAMPLE_CLOCK_SELECT}))
      else $error("config changed in frame");
   pat_delay_a: assert property ($changed(PATTERN_OUTPUT_ENABLE) |-> $past(SCS_B) && $past(SCS_B, 11))
      else $error("pattern switched early");
endmodule
bind phase_pattern_regs phase_pattern_monitor u_mon (.MCLK(MCLK), .RST_B(RST_B), .SCS_B(SCS_B),
   .CORE_A(CORE_A), .CORE_OR(CORE_OR), .PORT_A(PORT_A), .PORT_B(PORT_B), .PORT_C(PORT_C), .PORT_D(PORT_D),
   .OUT_OF_RANGE(OUT_OF_RANGE), .PHASE_ADJUST_ENABLE(PHASE_ADJUST_ENABLE),
   .FINE_DELAY_MAGNITUDE(FINE_DELAY_MAGNITUDE), .COARSE_DELAY_MAGNITUDE(COARSE_DELAY_MAGNITUDE),
   .SLOW_SAMPLE_CLOCK_SELECT(SLOW_SAMPLE_CLOCK_SELECT), .PATTERN_OUTPUT_ENABLE(PATTERN_OUTPUT_ENABLE));
`default_nettype wire

/* File: tb/clock_phase_test_pattern_regs_tb.sv */
/*
 Testbench: register writes, gating and test pattern.
 Assumes serial_host as the writing party.
*/
`timescale 1ns/1ns
`default_nettype none
module clock_phase_test_pattern_regs_tb;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic ddr = 1'b0;
   logic [31:0] core_w = 32'h5AC33C96;
   logic core_or = 1'b1;
   wire logic [31:0] port_w;
   wire logic sclk, scs_b, sdata, oor, pae, slow, pen;
   wire logic [8:0] fine;
   wire logic [3:0] coarse;
   int error_cnt = 0;
   int n_compared = 0;
   int k;
   logic [9:0] seq = 10'h14A;
   always #20 mclk = ~mclk;
   serial_host u_host (.MCLK(mclk), .SCLK(sclk), .SCS_B(scs_b), .SDATA(sdata));
   phase_pattern_regs u_dut (.MCLK(mclk), .RST_B(rst_b), .SCLK(sclk), .SCS_B(scs_b), .SDATA(sdata),
      .DDR_MODE(ddr), .CORE_A(core_w[31:24]), .CORE_B(core_w[23:16]), .CORE_C(core_w[15:8]),
      .CORE_D(core_w[7:0]), .CORE_OR(core_or), .PORT_A(port_w[31:24]), .PORT_B(port_w[23:16]),
      .PORT_C(port_w[15:8]), .PORT_D(port_w[7:0]), .OUT_OF_RANGE(oor), .PHASE_ADJUST_ENABLE(pae),
      .FINE_DELAY_MAGNITUDE(fine), .COARSE_DELAY_MAGNITUDE(coarse), .SLOW_SAMPLE_CLOCK_SELECT(slow),
      .PATTERN_OUTPUT_ENABLE(pen));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [31:0] exp);
      u_host.send(a, d);
      repeat (3) @(negedge mclk);
      check("config", 32'({pae, fine, coarse, slow}), exp);
   endtask
   task automatic wait_pen(input logic v);
      k = 0;
      while (pen !== v && k < 40) begin
         @(negedge mclk);
         k++;
      end
      if (k == 40) begin
         error_cnt++;
         finish_test();
      end
   endtask
   initial begin
      repeat (10) @(negedge mclk);
      rst_b = 1'b1;
      repeat (3) @(negedge mclk);
      check("config", 32'({pae, fine, coarse, slow, pen}), 32'h0);
      check("port", port_w, core_w);
      check("flag", 32'(oor), 32'(core_or));
      $display("test reset done");
      wr(4'hE, 16'hD7FF, 32'h4015);
      wr(4'hD, 16'hAAFF, 32'h6AB5);
      wr(4'hC, 16'h0000, 32'h6AB5);
      wr(4'hE, 16'h57FF, 32'h0001);
      wr(4'hD, 16'hFFFF, 32'h0001);
      wr(4'hE, 16'hD7FF, 32'h7FF5);
      $display("test config done");
      u_host.send(4'hF, 16'hFFFF);
      wait_pen(1'b1);
      check("delay", 32'(k >= 8 && k <= 12), 32'h1);
      for (int i = 0; i < 30; i++) begin
         ddr = (i >= 15);
         check("pattern", port_w, seq[9 - (i % 10)] ? 32'hFEFDFCFB : 32'h01020304);
         check("flag", 32'(oor), 32'(seq[9 - (i % 10)]));
         @(negedge mclk);
      end
      u_host.send(4'hF, 16'hF7FF);
      wait_pen(1'b0);
      core_w = 32'h11223344;
      core_or = 1'b0;
      repeat (2) @(negedge mclk);
      check("port", port_w, core_w);
      check("flag", 32'(oor), 32'(core_or));
      $display("test pattern done");
      rst_b = 1'b0;
      @(negedge mclk);
      check("config", 32'({pae, fine, coarse, slow, pen}), 32'h0);
      repeat (9) @(negedge mclk);
      rst_b = 1'b1;
      repeat (3) @(negedge mclk);
      check("config", 32'({pae, fine, coarse, slow, pen}), 32'h0);
      check("port", port_w, core_w);
      $display("test second reset done");
      finish_test();
   end
endmodule
`default_nettype wire
